// ### inc/pic_pkg.sv
// Purpose: Shared constants for the interrupt condition logic.
// Assumes: Byte-wide management bus with 6-bit register offsets.
// Notes:   Offsets are the printed register numbers.
package pic_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFF_SWITCH_CONFIG = 6'h01;
  localparam logic [5:0] OFF_INT_COND = 6'h02;
  localparam logic [5:0] OFF_INT_MASK = 6'h03;
  localparam logic [5:0] OFF_XMIT_STATE = 6'h04;
  localparam logic [5:0] OFF_RX_COND_A = 6'h09;
  localparam logic [5:0] OFF_RX_COND_B = 6'h0a;
  localparam logic [5:0] OFF_INT_COMPARE = 6'h1a;
  localparam logic [5:0] OFF_XMIT_COMPARE = 6'h1b;
  localparam logic [5:0] OFF_RX_COMPARE_A = 6'h1c;
  localparam logic [5:0] OFF_RX_COMPARE_B = 6'h1d;
  localparam logic [5:0] OFF_LINK_COMPARE = 6'h1f;
  localparam logic [5:0] OFF_LINK_COND = 6'h20;
  // Read-only registers
  localparam logic [5:0] OFF_RX_STATE = 6'h08;
  localparam logic [5:0] OFF_NOISE_COUNT = 6'h0f;
  localparam logic [5:0] OFF_NOISE_PRESCALE = 6'h10;
  localparam logic [5:0] OFF_STATE_COUNT = 6'h13;
  localparam logic [5:0] OFF_STATE_PRESCALE = 6'h14;
  localparam logic [5:0] OFF_LINK_ERR_COUNT = 6'h16;
  localparam logic [5:0] OFF_IDENT = 6'h18;
  localparam logic [5:0] OFF_INJECT_COUNT = 6'h19;
  localparam logic [5:0] OFF_SCRUB_TIMER = 6'h25;
  // ---------------------------------------------------------------
  // Event bit positions, plus the parity enable bit of the transmit state register
  // ---------------------------------------------------------------
  localparam int BIT_REQ_PARITY = 0;
  localparam int BIT_BUS_PARITY = 1;
  localparam int BIT_RO_REJECT = 2;
  localparam int BIT_COND_INHIBIT = 3;
  localparam int BIT_LINK_THRESH = 4;
  localparam int BIT_RX_SUM_A = 5;
  localparam int BIT_RX_SUM_B = 6;
  localparam int BIT_USER_SENSE = 7;
  localparam int BIT_REQ_PAR_EN = 6;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_INT_MASK = 8'h00;
  localparam logic [7:0] RST_INT_COND = 8'h10;
  localparam logic [7:0] RST_COMPARE = 8'h00;
endpackage : pic_pkg

// ### logic/pic_compare_file.sv
// Purpose: Compare registers for the conditionally writable registers.
// Assumes: One write port, one registered read port.
// Notes:   Index 0..4 = interrupt, transmit, rx A, rx B, link mgmt.
module pic_compare_file
  import pic_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 5
) (
  input wire logic core_clk, // Device clock
  input wire logic reset, // Synchronous reset
  input wire logic clk_en, // Freezes state when low
  input wire logic wr_en, // Write strobe
  input wire logic [2:0] wr_idx, // Write index
  input wire logic [WIDTH-1:0] wr_data, // Write data
  input wire logic [2:0] rd_idx, // Read index
  output logic [WIDTH-1:0] rd_data, // Registered read data
  output logic [WIDTH-1:0] all_data [DEPTH] // Live values
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      always_ff @(posedge core_clk) begin
        if (reset) begin
          mem_r[g] <= RST_COMPARE;
        end else if (clk_en && wr_en && wr_idx == 3'(g)) begin
          mem_r[g] <= wr_data;
        end
      end
      assign all_data[g] = mem_r[g];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_data <= '0;
    end else if (clk_en) begin
      rd_data <= (int'(rd_idx) < DEPTH) ? mem_r[rd_idx] : '0;
    end
  end
endmodule // pic_compare_file

// ### logic/pic_int_logic.sv
// Purpose: Interrupt condition, mask and compare logic of the PHY.
// Assumes: Bus strobes are one-cycle pulses synchronous to core_clk.
// Notes:   Conditional registers other than the interrupt condition
//          register live elsewhere; this block only gives the bit mask
//          that may be written for them and flags the inhibit event.

// Summary of operation
// - Interrupt asserts when a condition bit and its mask bit are both one.
// - Request parity event needs parity enable in transmit state register.
// - Only data entering the transmitter is parity checked.
// - Bus parity error on a write sets event bit one.
// - Write to any read-only register sets event bit two.
// - Bits differing from compare stay unwritten and set the inhibit bit.
// - Pairings: 02-1A, 04-1B, 09-1C, 0A-1D, 20-1F.
// - Inhibit bit stays set until software clears it.
// - Switch configuration writes are refused while scrubbing.
// - Link monitor counter at zero sets event bit four, sticky.
// - After reset event bit four reads one.
// - Summary A set by masked condition A; clears only once gone.
// - Summary B set by masked condition B; clears only once gone.
// - User sense event set by any sense bit; clears only once all zero.
// - Mask register at 03h, always read-write, cleared by reset.
// - Interrupt output is active low.
module pic_int_logic
  import pic_pkg::*;
(
  input wire logic core_clk, // Device clock, 20 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic clk_en, // Clock enable
  input wire logic bus_wr, // Management bus write strobe
  input wire logic bus_rd, // Management bus read strobe
  input wire logic [5:0] bus_addr, // Register offset
  input wire logic [7:0] mgmt_bus_data, // Write data lines
  input wire logic mgmt_bus_parity, // Odd parity line
  input wire logic bus_parity_en, // Bus parity checking enabled
  output logic [7:0] bus_rdata, // Read data, registered
  input wire logic [7:0] xmit_req_data, // Request data into transmitter
  input wire logic xmit_req_parity, // Its parity bit
  input wire logic xmit_req_valid, // Data enters transmitter
  input wire logic [7:0] transmit_state_reg, // Current transmit state
  input wire logic [7:0] receive_condition_a, // Receive condition A
  input wire logic [7:0] receive_mask_a, // Receive mask A
  input wire logic [7:0] receive_condition_b, // Receive condition B
  input wire logic [7:0] receive_mask_b, // Receive mask B
  input wire logic [7:0] link_mgmt_condition, // Link mgmt condition
  input wire logic [2:0] user_sense_reg, // Sense bits two..zero
  input wire logic link_err_count_zero, // Link error counter is zero
  input wire logic scrub_active, // Scrubbing in progress
  output logic [7:0] cond_wr_mask, // Bits allowed in a conditional write
  output logic switch_config_wr_ok, // Switch config write accepted
  output logic int_n // Interrupt, active low
);
  logic [7:0] interrupt_condition_reg_r;
  logic [7:0] interrupt_condition_reg_nxt;
  logic [7:0] interrupt_mask_reg_r;
  logic [7:0] cmp_rdata;
  logic [7:0] cmp_all [5];
  logic [7:0] cur_val;
  logic [2:0] cmp_widx;
  logic cmp_wr;
  logic cond_hit;
  logic ro_hit;
  logic bus_par_bad;
  logic req_par_bad;
  logic inhibit;
  logic sum_a;
  logic sum_b;
  logic sense_any;
  logic rd_is_cmp_r;
  logic [7:0] local_rd_r;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic [2:0] cmp_index(input logic [5:0] a);
    case (a)
      OFF_INT_COMPARE: cmp_index = 3'h0;
      OFF_XMIT_COMPARE: cmp_index = 3'h1;
      OFF_RX_COMPARE_A: cmp_index = 3'h2;
      OFF_RX_COMPARE_B: cmp_index = 3'h3;
      OFF_LINK_COMPARE: cmp_index = 3'h4;
      default: cmp_index = 3'h7;
    endcase
  endfunction

  // Conditional register offset to its compare index
  function automatic logic [2:0] cond_index(input logic [5:0] a);
    case (a)
      OFF_INT_COND: cond_index = 3'h0;
      OFF_XMIT_STATE: cond_index = 3'h1;
      OFF_RX_COND_A: cond_index = 3'h2;
      OFF_RX_COND_B: cond_index = 3'h3;
      OFF_LINK_COND: cond_index = 3'h4;
      default: cond_index = 3'h7;
    endcase
  endfunction

  function automatic logic is_read_only(input logic [5:0] a);
    case (a)
      OFF_RX_STATE, OFF_NOISE_COUNT, OFF_NOISE_PRESCALE,
      OFF_STATE_COUNT, OFF_STATE_PRESCALE, OFF_LINK_ERR_COUNT,
      OFF_IDENT, OFF_INJECT_COUNT, OFF_SCRUB_TIMER: is_read_only = 1'b1;
      default: is_read_only = 1'b0;
    endcase
  endfunction

  assign cmp_widx = cmp_index(bus_addr);
  assign cmp_wr = bus_wr && cmp_widx != 3'h7;
  assign cond_hit = bus_wr && cond_index(bus_addr) != 3'h7;
  assign ro_hit = bus_wr && is_read_only(bus_addr);

  // ---------------------------------------------------------------
  // Conditional write guard
  // ---------------------------------------------------------------
  always_comb begin
    case (cond_index(bus_addr))
      3'h0: cur_val = interrupt_condition_reg_r;
      3'h1: cur_val = transmit_state_reg;
      3'h2: cur_val = receive_condition_a;
      3'h3: cur_val = receive_condition_b;
      3'h4: cur_val = link_mgmt_condition;
      default: cur_val = 8'h00;
    endcase
  end

  // Bits changed since the last read must not be overwritten
  assign cond_wr_mask = cond_hit ?
    ~(cur_val ^ cmp_all[cond_index(bus_addr)]) : 8'h00;
  assign inhibit = cond_hit && cond_wr_mask != 8'hff;
  // Scrubbing blocks the switch; refusal is silent
  assign switch_config_wr_ok = bus_wr && bus_addr == OFF_SWITCH_CONFIG
    && !scrub_active;

  // ---------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------
  // Odd parity across data plus parity line
  assign bus_par_bad = bus_wr && bus_parity_en &&
    !(^{mgmt_bus_data, mgmt_bus_parity});
  // Only data actually entering the transmitter is checked
  assign req_par_bad = xmit_req_valid &&
    transmit_state_reg[BIT_REQ_PAR_EN] &&
    !(^{xmit_req_data, xmit_req_parity});
  assign sum_a = |(receive_condition_a & receive_mask_a);
  assign sum_b = |(receive_condition_b & receive_mask_b);
  assign sense_any = |user_sense_reg;

  // ---------------------------------------------------------------
  // Interrupt condition register
  // ---------------------------------------------------------------
  always_comb begin
    interrupt_condition_reg_nxt = interrupt_condition_reg_r;
    // Accepted write: only bits matching the compare register change
    if (bus_wr && bus_addr == OFF_INT_COND) begin
      interrupt_condition_reg_nxt = (interrupt_condition_reg_r &
        ~cond_wr_mask) | (mgmt_bus_data & cond_wr_mask);
    end
    // Sets win over a clear in the same cycle
    if (req_par_bad) interrupt_condition_reg_nxt[BIT_REQ_PARITY] = 1'b1;
    if (bus_par_bad) interrupt_condition_reg_nxt[BIT_BUS_PARITY] = 1'b1;
    if (ro_hit) interrupt_condition_reg_nxt[BIT_RO_REJECT] = 1'b1;
    if (inhibit) interrupt_condition_reg_nxt[BIT_COND_INHIBIT] = 1'b1;
    if (link_err_count_zero) begin
      interrupt_condition_reg_nxt[BIT_LINK_THRESH] = 1'b1;
    end
    // Level sources cannot be cleared while still active
    if (sum_a) interrupt_condition_reg_nxt[BIT_RX_SUM_A] = 1'b1;
    if (sum_b) interrupt_condition_reg_nxt[BIT_RX_SUM_B] = 1'b1;
    if (sense_any) begin
      interrupt_condition_reg_nxt[BIT_USER_SENSE] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      interrupt_condition_reg_r <= RST_INT_COND;
    end else if (clk_en) begin
      interrupt_condition_reg_r <= interrupt_condition_reg_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      interrupt_mask_reg_r <= RST_INT_MASK;
    end else if (clk_en && bus_wr && bus_addr == OFF_INT_MASK) begin
      interrupt_mask_reg_r <= mgmt_bus_data;
    end
  end

  assign int_n = ~|(interrupt_condition_reg_r & interrupt_mask_reg_r);

  // ---------------------------------------------------------------
  // Compare registers and read path
  // ---------------------------------------------------------------
  pic_compare_file #(.WIDTH(8), .DEPTH(5)) u_cmp (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .wr_en(cmp_wr),
    .wr_idx(cmp_widx),
    .wr_data(mgmt_bus_data),
    .rd_idx(cmp_index(bus_addr)),
    .rd_data(cmp_rdata),
    .all_data(cmp_all)
  );

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_is_cmp_r <= 1'b0;
      local_rd_r <= 8'h00;
    end else if (clk_en && bus_rd) begin
      rd_is_cmp_r <= cmp_index(bus_addr) != 3'h7;
      case (bus_addr)
        OFF_INT_COND: local_rd_r <= interrupt_condition_reg_r;
        OFF_INT_MASK: local_rd_r <= interrupt_mask_reg_r;
        default: local_rd_r <= 8'h00;
      endcase
    end
  end

  assign bus_rdata = rd_is_cmp_r ? cmp_rdata : local_rd_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  inhibit_sets_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && inhibit |=> interrupt_condition_reg_r[BIT_COND_INHIBIT])
    else $error("inhibited write did not flag");
  inhibit_holds_a: assert property (@(posedge core_clk) disable iff (reset)
    interrupt_condition_reg_r[BIT_COND_INHIBIT] &&
    !(bus_wr && bus_addr == OFF_INT_COND) |=>
    interrupt_condition_reg_r[BIT_COND_INHIBIT])
    else $error("inhibit bit dropped by itself");
  ro_reject_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && ro_hit |=> interrupt_condition_reg_r[BIT_RO_REJECT])
    else $error("read-only write not flagged");
  int_level_a: assert property (@(posedge core_clk) disable iff (reset)
    int_n == !(|(interrupt_condition_reg_r & interrupt_mask_reg_r)))
    else $error("interrupt level wrong");
  sum_a_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && sum_a |=> interrupt_condition_reg_r[BIT_RX_SUM_A])
    else $error("summary A not held");
  sum_b_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && sum_b |=> interrupt_condition_reg_r[BIT_RX_SUM_B])
    else $error("summary B not held");
  sense_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && sense_any |=>
    interrupt_condition_reg_r[BIT_USER_SENSE])
    else $error("sense event not held");
  scrub_block_a: assert property (@(posedge core_clk) disable iff (reset)
    scrub_active |-> !switch_config_wr_ok)
    else $error("switch write during scrub");
  reset_thresh_a: assert property (@(posedge core_clk)
    $fell(reset) |-> interrupt_condition_reg_r[BIT_LINK_THRESH]
    && interrupt_mask_reg_r == 8'h00)
    else $error("reset values wrong");
  req_par_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && req_par_bad |=>
    interrupt_condition_reg_r[BIT_REQ_PARITY])
    else $error("request parity not flagged");
  // A low enable must hold every latched event, whatever strobes arrive
  sequence frozen_s;
    !clk_en && !reset;
  endsequence
  freeze_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    frozen_s |=> $stable(interrupt_condition_reg_r) &&
    $stable(interrupt_mask_reg_r))
    else $error("state moved while clock enable low");
endmodule // pic_int_logic

// ### testbench/pic_mgmt_proc.sv
// Purpose: Management processor model on the byte-wide register bus.
// Assumes: Strobes taken at a rising edge, read data one cycle later.
// Notes:   Released data lines show the inverse of the last value.
module pic_mgmt_proc
  import pic_pkg::*;
(
  input wire logic core_clk, // Device clock
  input wire logic [7:0] bus_rdata, // Read data
  input wire logic [7:0] cond_wr_mask, // Writable bits
  input wire logic switch_config_wr_ok, // Switch write accepted
  output logic bus_wr, // Write strobe
  output logic bus_rd, // Read strobe
  output logic [5:0] bus_addr, // Offset
  output logic [7:0] mgmt_bus_data, // Data lines
  output logic mgmt_bus_parity, // Odd parity line
  output logic [7:0] mask_seen, // Writable bits in last write
  output logic ok_seen // Switch accept in last write
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 6'h00;
    mgmt_bus_data = 8'h00;
    mgmt_bus_parity = 1'b1;
    mask_seen = 8'h00;
    ok_seen = 1'b0;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic bad);
    @(posedge core_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    mgmt_bus_data <= d;
    mgmt_bus_parity <= ~^d ^ bad;
    @(negedge core_clk);
    mask_seen = cond_wr_mask;
    ok_seen = switch_config_wr_ok;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    // Stale data must not look like a held bus
    mgmt_bus_data <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    @(negedge core_clk);
    d = bus_rdata;
  endtask
  // Read first so the compare register holds what was seen
  task automatic clr(input logic [7:0] bits);
    logic [7:0] v;
    rd(OFF_INT_COND, v);
    wr(OFF_INT_COMPARE, v, 1'b0);
    wr(OFF_INT_COND, v & ~bits, 1'b0);
  endtask
endmodule // pic_mgmt_proc

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the interrupt condition logic.
// Assumes: Clock enable high and bus parity checking enabled, except in t_freeze.
// Notes:   Condition reads go through the processor model.
module tb_top;
  import pic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, clk_en, bus_wr, bus_rd, mgmt_bus_parity;
  logic bus_parity_en, xmit_req_parity, xmit_req_valid;
  logic link_err_count_zero, scrub_active, switch_config_wr_ok, int_n;
  logic ok_seen;
  logic [5:0] bus_addr;
  logic [7:0] mgmt_bus_data, bus_rdata, xmit_req_data, cond_wr_mask;
  logic [7:0] transmit_state_reg, receive_condition_a, receive_mask_a;
  logic [7:0] receive_condition_b, receive_mask_b, link_mgmt_condition;
  logic [7:0] mask_seen;
  logic [2:0] user_sense_reg;
  int bad_count = 0;
  int total_checks = 0;
  pic_int_logic u_pic_int_logic (.core_clk, .reset, .clk_en, .bus_wr,
    .bus_rd, .bus_addr, .mgmt_bus_data, .mgmt_bus_parity, .bus_parity_en,
    .bus_rdata, .xmit_req_data, .xmit_req_parity, .xmit_req_valid,
    .transmit_state_reg, .receive_condition_a, .receive_mask_a,
    .receive_condition_b, .receive_mask_b, .link_mgmt_condition,
    .user_sense_reg, .link_err_count_zero, .scrub_active, .cond_wr_mask,
    .switch_config_wr_ok, .int_n);
  pic_mgmt_proc u_pic_mgmt_proc (.core_clk, .bus_rdata, .cond_wr_mask,
    .switch_config_wr_ok, .bus_wr, .bus_rd, .bus_addr, .mgmt_bus_data,
    .mgmt_bus_parity, .mask_seen, .ok_seen);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_pic_mgmt_proc.rd(a, v);
    chk(v, exp);
  endtask
  task automatic set_src(input int k, input logic [7:0] v);
    @(posedge core_clk);
    case (k)
      0: transmit_state_reg <= v;
      1: receive_condition_a <= v;
      2: receive_condition_b <= v;
      default: link_mgmt_condition <= v;
    endcase
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_mask;
    rdchk(OFF_INT_COND, 8'h10);
    rdchk(OFF_INT_MASK, 8'h00);
    chk({7'h00, int_n}, 8'h01);
    u_pic_mgmt_proc.wr(OFF_INT_MASK, 8'h10, 1'b0);
    rdchk(OFF_INT_MASK, 8'h10);
    chk({7'h00, int_n}, 8'h00);
    u_pic_mgmt_proc.clr(8'h10);
    rdchk(OFF_INT_COND, 8'h00);
    chk({7'h00, int_n}, 8'h01);
    u_pic_mgmt_proc.wr(OFF_INT_MASK, 8'hff, 1'b0);
  endtask
  task automatic t_link_inhibit;
    @(posedge core_clk);
    link_err_count_zero <= 1'b1;
    @(posedge core_clk);
    link_err_count_zero <= 1'b0;
    repeat (5) @(posedge core_clk);
    rdchk(OFF_INT_COND, 8'h10);
    // Stale compare: the new event bit must survive the clear
    u_pic_mgmt_proc.wr(OFF_INT_COMPARE, 8'h00, 1'b0);
    u_pic_mgmt_proc.wr(OFF_INT_COND, 8'h00, 1'b0);
    chk(u_pic_mgmt_proc.mask_seen, 8'hef);
    rdchk(OFF_INT_COND, 8'h18);
    repeat (20) @(posedge core_clk);
    rdchk(OFF_INT_COND, 8'h18);
    u_pic_mgmt_proc.clr(8'h18);
    rdchk(OFF_INT_COND, 8'h00);
  endtask
  task automatic t_bus_ro;
    logic [5:0] ro [9];
    ro = '{OFF_RX_STATE, OFF_NOISE_COUNT, OFF_NOISE_PRESCALE,
      OFF_STATE_COUNT, OFF_STATE_PRESCALE, OFF_LINK_ERR_COUNT, OFF_IDENT,
      OFF_INJECT_COUNT, OFF_SCRUB_TIMER};
    u_pic_mgmt_proc.wr(OFF_XMIT_COMPARE, 8'h00, 1'b1);
    repeat (3) @(posedge core_clk);
    rdchk(OFF_INT_COND, 8'h02);
    u_pic_mgmt_proc.clr(8'h02);
    for (int i = 0; i < 9; i++) begin
      u_pic_mgmt_proc.wr(ro[i], 8'h5a, 1'b0);
      rdchk(OFF_INT_COND, 8'h04);
      u_pic_mgmt_proc.clr(8'h04);
    end
    rdchk(OFF_INT_COND, 8'h00);
  endtask
  task automatic t_req_parity;
    @(posedge core_clk);
    xmit_req_data <= 8'h01;
    xmit_req_parity <= 1'b1;
    xmit_req_valid <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdchk(OFF_INT_COND, 8'h00);
    @(posedge core_clk);
    transmit_state_reg <= 8'h40;
    xmit_req_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdchk(OFF_INT_COND, 8'h00);
    @(posedge core_clk);
    xmit_req_valid <= 1'b1;
    @(posedge core_clk);
    xmit_req_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdchk(OFF_INT_COND, 8'h01);
    u_pic_mgmt_proc.clr(8'h01);
  endtask
  task automatic t_pairs;
    logic [5:0] reg_off [4];
    logic [5:0] cmp_off [4];
    reg_off = '{OFF_XMIT_STATE, OFF_RX_COND_A, OFF_RX_COND_B, OFF_LINK_COND};
    cmp_off = '{OFF_XMIT_COMPARE, OFF_RX_COMPARE_A, OFF_RX_COMPARE_B,
      OFF_LINK_COMPARE};
    for (int k = 0; k < 4; k++) begin
      set_src(k, 8'h0f);
      u_pic_mgmt_proc.wr(cmp_off[k], 8'h0c, 1'b0);
      rdchk(cmp_off[k], 8'h0c);
      u_pic_mgmt_proc.wr(reg_off[k], 8'h55, 1'b0);
      chk(u_pic_mgmt_proc.mask_seen, 8'hfc);
      rdchk(OFF_INT_COND, 8'h08);
      u_pic_mgmt_proc.clr(8'h08);
      set_src(k, 8'h00);
    end
  endtask
  task automatic t_scrub;
    @(posedge core_clk);
    scrub_active <= 1'b1;
    u_pic_mgmt_proc.wr(OFF_SWITCH_CONFIG, 8'h11, 1'b0);
    chk({7'h00, u_pic_mgmt_proc.ok_seen}, 8'h00);
    scrub_active <= 1'b0;
    u_pic_mgmt_proc.wr(OFF_SWITCH_CONFIG, 8'h11, 1'b0);
    chk({7'h00, u_pic_mgmt_proc.ok_seen}, 8'h01);
  endtask
  task automatic t_summary(input int k, input logic on);
    @(posedge core_clk);
    case (k)
      0: {receive_condition_a, receive_mask_a} <= {8'h01, {7'h00, on}};
      1: {receive_condition_b, receive_mask_b} <= {8'h80, {on, 7'h00}};
      default: user_sense_reg <= {on, 2'b00};
    endcase
  endtask
  task automatic t_sources;
    logic [7:0] b;
    for (int k = 0; k < 3; k++) begin
      b = 8'h20 << k;
      t_summary(k, 1'b1);
      rdchk(OFF_INT_COND, b);
      chk({7'h00, int_n}, 8'h00);
      u_pic_mgmt_proc.clr(b);
      rdchk(OFF_INT_COND, b);
      t_summary(k, 1'b0);
      u_pic_mgmt_proc.clr(b);
      rdchk(OFF_INT_COND, 8'h00);
      chk({7'h00, int_n}, 8'h01);
    end
  endtask
  task automatic t_freeze;
    @(posedge core_clk);
    bus_parity_en <= 1'b0;
    u_pic_mgmt_proc.wr(OFF_INT_MASK, 8'h5a, 1'b1);
    rdchk(OFF_INT_COND, 8'h00);
    rdchk(OFF_INT_MASK, 8'h5a);
    // Frozen: a parity error, a counter expiry and a mask write are lost
    @(posedge core_clk);
    {clk_en, bus_parity_en, link_err_count_zero} <= 3'b011;
    u_pic_mgmt_proc.wr(OFF_INT_MASK, 8'hff, 1'b1);
    @(posedge core_clk);
    {clk_en, link_err_count_zero} <= 2'b10;
    rdchk(OFF_INT_COND, 8'h00);
    rdchk(OFF_INT_MASK, 8'h5a);
  endtask
  initial begin
    {reset, clk_en, bus_parity_en} = 3'b111;
    {xmit_req_data, xmit_req_parity, xmit_req_valid} = 10'h000;
    {transmit_state_reg, receive_condition_a, receive_mask_a} = 24'h0;
    {receive_condition_b, receive_mask_b, link_mgmt_condition} = 24'h0;
    {user_sense_reg, link_err_count_zero, scrub_active} = 5'h00;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_mask();
    t_link_inhibit();
    t_bus_ro();
    t_req_parity();
    t_pairs();
    t_scrub();
    t_sources();
    t_freeze();
    give_verdict();
  end
  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end
endmodule // tb_top
